// file: ccsr_alu_model.sv
// datapath model that feeds flag results into the register bank
// assumes operands and go arrive from the bench after a rising edge
`timescale 1ns/10ps
`default_nettype none
module ccsr_alu_model (
	input  wire logic        i_mclk, // core clock
	input  wire logic        i_go,   // start one operation
	input  wire logic        i_byte, // byte sized operation
	input  wire logic [15:0] i_a,    // operand a
	input  wire logic [15:0] i_b,    // operand b
	output logic             o_we,   // flag update pulse
	output logic             o_byte, // size seen by the bank
	output logic      [16:0] o_sum,  // raw sum with carry out
	output logic             o_ovf,  // signed overflow
	output logic             o_hc4,  // carry out of low nibble
	output logic             o_hc8   // carry out of low byte
);
	logic [8:0]  s8;
	logic [16:0] s16;
	assign s8  = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]};
	assign s16 = {1'b0, i_a} + {1'b0, i_b};
	// results valid only with the pulse; sum toggles when idle, other results hold
	always_ff @(posedge i_mclk) begin
		o_we <= i_go;
		o_byte <= i_byte;
		if (i_go) begin
			o_sum <= i_byte ? {8'h00, s8} : s16;
			o_ovf <= i_byte ? (i_a[7] == i_b[7]) && (s8[7] != i_a[7])
				: (i_a[15] == i_b[15]) && (s16[15] != i_a[15]);
			o_hc4 <= ({1'b0, i_a[3:0]} + {1'b0, i_b[3:0]}) > 5'h0F;
			o_hc8 <= s8[8];
		end else begin
			o_sum <= ~o_sum;
		end
	end
endmodule : ccsr_alu_model
`default_nettype wire

// file: ccsr_pkg.sv
// constants for the core status and control register bank
// assumes a 16-bit register port with byte offsets as printed
package ccsr_pkg;

	// ***************************************************************
	// register offsets
	// ***************************************************************
	localparam logic [7:0] ADDR_LOOP_CNT  = 8'h36;
	localparam logic [7:0] ADDR_STATUS    = 8'h42;
	localparam logic [7:0] ADDR_CORE_CTL  = 8'h44;
	localparam logic [7:0] ADDR_IRQ_HOLD  = 8'h52;
	localparam logic [7:0] ADDR_PC_HIGH   = 8'h60;
	localparam logic [7:0] ADDR_RD_PAGE   = 8'h62;
	localparam logic [7:0] ADDR_WR_PAGE   = 8'h64;
	localparam logic [7:0] ADDR_TBL_PAGE  = 8'h66;

	// ***************************************************************
	// widths and field positions
	// ***************************************************************
	localparam int W_LOOP   = 16;
	localparam int W_HOLD   = 14;
	localparam int W_PCH    = 8;
	localparam int W_RDPG   = 10;
	localparam int W_WRPG   = 9;
	localparam int W_TBLPG  = 8;
	localparam int B_HCARRY = 8;
	localparam int B_IPL_HI = 7;
	localparam int B_IPL_LO = 5;
	localparam int B_LOOPA  = 4;
	localparam int B_NEG    = 3;
	localparam int B_WRAP   = 2;
	localparam int B_ZERO   = 1;
	localparam int B_CARRY  = 0;
	localparam int B_IPLTOP = 3;
	localparam int B_PSV    = 2;

	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [15:0] PSV_WINDOW  = 16'h8000;
	localparam logic [2:0]  IPL_MASKALL = 3'h7;

endpackage : ccsr_pkg

// file: ccsr_regs.sv
// core status and control register bank
// Summary of operation
// - 16-bit loop count, read and write
// - half carry from bit 4 or 8
// - priority field bits 7:5, 7 masks all
// - priority field locked to software while nesting off
// - control bit 3 extends priority to four bits
// - loop active flag follows loop execution
// - negative flag from result sign
// - overflow flag from signed overflow
// - zero flag set by zero result, cleared by nonzero result
// - carry flag from msb carry out
// - view enable maps program into data space
// - high data read without view traps
// - 14-bit interrupt hold count, read write
// - exposes program counter high byte
// - 10-bit data read page
// - 9-bit data write page
// - 8-bit table page
// - table address is page concatenated above effective address
// assumes the datapath supplies flag results and counter updates
// assumes software accepts losing a write that meets a core update
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccsr_regs (
	input  wire logic        i_mclk,       // core clock, 25 MHz
	input  wire logic        i_rstn,       // async reset, low
	input  wire logic [7:0]  i_addr,       // register byte offset
	input  wire logic [15:0] i_wdata,      // write data
	input  wire logic        i_wr,         // write strobe
	input  wire logic        i_rd,         // read strobe
	output logic      [15:0] o_rdata,      // read data, next cycle
	input  wire logic        i_nesting_off,// interrupt nesting disable
	input  wire logic        i_flag_we,    // alu flags update
	input  wire logic        i_op_byte,    // byte sized operation
	input  wire logic [16:0] i_alu_sum,    // raw sum incl carry out
	input  wire logic        i_alu_ovf,    // signed overflow
	input  wire logic        i_hc4,        // carry out of bit 4 (3->4)
	input  wire logic        i_hc8,        // carry out of bit 8 (7->8)
	input  wire logic        i_loop_run,   // loop executing
	input  wire logic        i_loop_we,    // core loads loop count
	input  wire logic [15:0] i_loop_d,     // core loop count
	input  wire logic        i_hold_we,    // core loads hold count
	input  wire logic [13:0] i_hold_d,     // core hold count
	input  wire logic        i_ipl_we,     // core sets priority
	input  wire logic [3:0]  i_ipl_d,      // core priority value
	input  wire logic [7:0]  i_pc_high,    // live pc bits 23:16
	input  wire logic [15:0] i_dm_addr,    // data read address
	input  wire logic        i_dm_rd,      // data read request
	input  wire logic [15:0] i_tbl_ea,     // table effective address
	output logic      [3:0]  o_cpu_ipl,    // four-bit priority
	output logic             o_irq_masked, // user interrupts off
	output logic             o_psv_map,    // program view active
	output logic             o_addr_trap,  // address trap pulse
	output logic      [23:0] o_tbl_addr,   // table program address
	output logic      [9:0]  o_rd_page,    // read page select
	output logic      [8:0]  o_wr_page,    // write page select
	output logic      [15:0] o_loop_cnt,   // loop count
	output logic      [13:0] o_hold_cnt    // hold count
);
	// ***************************************************************
	// address decode
	// ***************************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// byte operations take their flags from the low byte of the result
	function automatic logic size_pick(input logic is_byte, input logic lo,
		input logic hi);
		size_pick = is_byte ? lo : hi;
	endfunction : size_pick

	// write strobes qualified by an exact offset match
	wire logic we_loop = i_wr && hit(i_addr, ccsr_pkg::ADDR_LOOP_CNT);
	wire logic we_stat = i_wr && hit(i_addr, ccsr_pkg::ADDR_STATUS);
	wire logic we_ctl  = i_wr && hit(i_addr, ccsr_pkg::ADDR_CORE_CTL);
	wire logic we_hold = i_wr && hit(i_addr, ccsr_pkg::ADDR_IRQ_HOLD);
	wire logic we_rdpg = i_wr && hit(i_addr, ccsr_pkg::ADDR_RD_PAGE);
	wire logic we_wrpg = i_wr && hit(i_addr, ccsr_pkg::ADDR_WR_PAGE);
	wire logic we_tbl  = i_wr && hit(i_addr, ccsr_pkg::ADDR_TBL_PAGE);

	// ***************************************************************
	// counters, with core updates overriding software
	// ***************************************************************
	logic [15:0] loop_q;
	logic [13:0] hold_q;

	// loop count, full word
	ccsr_word_reg #(.W(ccsr_pkg::W_LOOP)) u_loop (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_sw_we (we_loop),
		.i_sw_d  (i_wdata),
		.i_hw_we (i_loop_we),
		.i_hw_d  (i_loop_d),
		.o_q     (loop_q)
	);

	// hold count is 14 bits; the top two write bits are dropped
	ccsr_word_reg #(.W(ccsr_pkg::W_HOLD)) u_hold (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_sw_we (we_hold),
		.i_sw_d  (i_wdata[ccsr_pkg::W_HOLD-1:0]),
		.i_hw_we (i_hold_we),
		.i_hw_d  (i_hold_d),
		.o_q     (hold_q)
	);

	// counts go straight to the core sequencer
	assign o_loop_cnt = loop_q;
	assign o_hold_cnt = hold_q;

	// ***************************************************************
	// alu status word
	// ***************************************************************
	// one register per status, control and page field
	logic       hc_reg;
	logic [2:0] ipl_reg;
	logic       loopa_reg;
	logic       neg_reg;
	logic       wrap_reg;
	logic       zero_reg;
	logic       carry_reg;
	logic       ipltop_reg;
	logic       psv_reg;
	logic [9:0] rdpg_reg;
	logic [8:0] wrpg_reg;
	logic [7:0] tbl_reg;

	// flag values derived from the datapath result
	wire logic [15:0] res16   = i_alu_sum[15:0];
	wire logic        res_msb = size_pick(i_op_byte, res16[7], res16[15]);
	wire logic        res_nz  = size_pick(i_op_byte, res16[7:0] != 8'h00,
	                                      res16 != 16'h0000);
	wire logic        cy_out  = size_pick(i_op_byte, i_alu_sum[8],
	                                      i_alu_sum[16]);
	wire logic        hc_new  = size_pick(i_op_byte, i_hc4,
	                                      i_hc8);

	// priority field ignores software while nesting is off
	wire logic ipl_sw_ok = we_stat && !i_nesting_off;

	wire logic [2:0] ipl_next = i_ipl_we ? i_ipl_d[2:0]
		: (ipl_sw_ok ? i_wdata[ccsr_pkg::B_IPL_HI:ccsr_pkg::B_IPL_LO]
		: ipl_reg);
	wire logic ipltop_next = i_ipl_we ? i_ipl_d[3]
		: (we_ctl ? i_wdata[ccsr_pkg::B_IPLTOP] : ipltop_reg);

	// hardware flag update outranks a software write in the same cycle
	wire logic hc_next   = i_flag_we ? hc_new
		: (we_stat ? i_wdata[ccsr_pkg::B_HCARRY] : hc_reg);
	wire logic neg_next  = i_flag_we ? res_msb
		: (we_stat ? i_wdata[ccsr_pkg::B_NEG] : neg_reg);
	wire logic wrap_next = i_flag_we ? i_alu_ovf
		: (we_stat ? i_wdata[ccsr_pkg::B_WRAP] : wrap_reg);
	wire logic carry_next = i_flag_we ? cy_out
		: (we_stat ? i_wdata[ccsr_pkg::B_CARRY] : carry_reg);
	// zero flag: only a nonzero result clears, a zero result sets
	wire logic zero_next = i_flag_we ? (res_nz ? 1'b0 : 1'b1)
		: (we_stat ? i_wdata[ccsr_pkg::B_ZERO] : zero_reg);
	// loop flag follows the sequencer; software writes to it are dropped
	wire logic loopa_next = i_loop_run;

	// ***************************************************************
	// status flag registers
	// ***************************************************************
	// half carry flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			hc_reg <= 1'b0;
		end else begin
			hc_reg <= hc_next;
		end
	end

	// priority field, three low bits of the level
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ipl_reg <= 3'h0;
		end else begin
			ipl_reg <= ipl_next;
		end
	end

	// loop active flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			loopa_reg <= 1'b0;
		end else begin
			loopa_reg <= loopa_next;
		end
	end

	// negative flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			neg_reg <= 1'b0;
		end else begin
			neg_reg <= neg_next;
		end
	end

	// signed overflow flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wrap_reg <= 1'b0;
		end else begin
			wrap_reg <= wrap_next;
		end
	end

	// zero flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			zero_reg <= 1'b0;
		end else begin
			zero_reg <= zero_next;
		end
	end

	// carry flag
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			carry_reg <= 1'b0;
		end else begin
			carry_reg <= carry_next;
		end
	end

	// ***************************************************************
	// core control word
	// ***************************************************************
	// priority top bit, core load beats software
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ipltop_reg <= 1'b0;
		end else begin
			ipltop_reg <= ipltop_next;
		end
	end

	// view bit is only ever written by software, with the whole control word
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			psv_reg <= 1'b0;
		end else if (we_ctl) begin
			psv_reg <= i_wdata[ccsr_pkg::B_PSV];
		end
	end

	// ***************************************************************
	// page registers
	// ***************************************************************
	// read page select
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdpg_reg <= 10'h000;
		end else if (we_rdpg) begin
			rdpg_reg <= i_wdata[ccsr_pkg::W_RDPG-1:0];
		end
	end

	// write page select
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wrpg_reg <= 9'h000;
		end else if (we_wrpg) begin
			wrpg_reg <= i_wdata[ccsr_pkg::W_WRPG-1:0];
		end
	end

	// table page select
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tbl_reg <= 8'h00;
		end else if (we_tbl) begin
			tbl_reg <= i_wdata[ccsr_pkg::W_TBLPG-1:0];
		end
	end

	// ***************************************************************
	// outputs to the core
	// ***************************************************************
	assign o_cpu_ipl    = {ipltop_reg, ipl_reg};
	assign o_irq_masked = ipltop_reg
		|| (ipl_reg == ccsr_pkg::IPL_MASKALL);
	assign o_psv_map    = psv_reg;
	assign o_rd_page    = rdpg_reg;
	assign o_wr_page    = wrpg_reg;
	assign o_tbl_addr   = {tbl_reg, i_tbl_ea};

	// trap is a one-cycle registered pulse after the offending read
	logic trap_reg;
	wire logic trap_next = i_dm_rd && !psv_reg
		&& (i_dm_addr >= ccsr_pkg::PSV_WINDOW);

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			trap_reg <= 1'b0;
		end else begin
			trap_reg <= trap_next;
		end
	end
	assign o_addr_trap = trap_reg;

	// ***************************************************************
	// read port
	// ***************************************************************
	wire logic [15:0] stat_word = {7'h00, hc_reg, ipl_reg, loopa_reg,
		neg_reg, wrap_reg, zero_reg, carry_reg};
	wire logic [15:0] ctl_word  = {12'h000, ipltop_reg, psv_reg, 2'h0};

	// unmapped offsets read as zero
	wire logic [15:0] rd_mux =
		hit(i_addr, ccsr_pkg::ADDR_LOOP_CNT) ? loop_q :
		hit(i_addr, ccsr_pkg::ADDR_STATUS)   ? stat_word :
		hit(i_addr, ccsr_pkg::ADDR_CORE_CTL) ? ctl_word :
		hit(i_addr, ccsr_pkg::ADDR_IRQ_HOLD) ? {2'h0, hold_q} :
		hit(i_addr, ccsr_pkg::ADDR_PC_HIGH)  ? {8'h00, i_pc_high} :
		hit(i_addr, ccsr_pkg::ADDR_RD_PAGE)  ? {6'h00, rdpg_reg} :
		hit(i_addr, ccsr_pkg::ADDR_WR_PAGE)  ? {7'h00, wrpg_reg} :
		hit(i_addr, ccsr_pkg::ADDR_TBL_PAGE) ? {8'h00, tbl_reg} :
		ccsr_pkg::RST_WORD;

	// zero outside the read slot so stale data never lingers
	logic [15:0] rdata_reg;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_reg <= 16'h0000;
		end else if (i_rd) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign o_rdata = rdata_reg;

endmodule : ccsr_regs
`default_nettype wire

// file: ccsr_regs_sva.sv
// timing checks on the register bank ports
// assumes binding to ccsr_regs, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ccsr_regs_sva (
	input wire logic        i_mclk,        // core clock
	input wire logic        i_rstn,        // async reset, low
	input wire logic [7:0]  i_addr,        // register offset
	input wire logic [15:0] i_wdata,       // write data
	input wire logic        i_wr,          // write strobe
	input wire logic        i_rd,          // read strobe
	input wire logic [15:0] o_rdata,       // read data
	input wire logic        i_nesting_off, // nesting disable
	input wire logic        i_loop_we,     // core loop load
	input wire logic        i_hold_we,     // core hold load
	input wire logic [13:0] i_hold_d,      // core hold value
	input wire logic        i_ipl_we,      // core priority load
	input wire logic [15:0] i_dm_addr,     // data read address
	input wire logic        i_dm_rd,       // data read request
	input wire logic [15:0] i_tbl_ea,      // table ea
	input wire logic [3:0]  o_cpu_ipl,     // priority level
	input wire logic        o_irq_masked,  // user irqs off
	input wire logic        o_psv_map,     // program view
	input wire logic        o_addr_trap,   // trap pulse
	input wire logic [23:0] o_tbl_addr,    // table address
	input wire logic [9:0]  o_rd_page,     // read page
	input wire logic [15:0] o_loop_cnt,    // loop count
	input wire logic [13:0] o_hold_cnt     // hold count
);
	// ***************************************************************
	// port relations
	// ***************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside read slot");
	loop_write_a: assert property (i_wr && i_addr == 8'h36 && !i_loop_we
		|=> o_loop_cnt == $past(i_wdata)) else $error("loop count write lost");
	hold_load_a: assert property (i_hold_we |=> o_hold_cnt == $past(i_hold_d))
		else $error("hold count load lost");
	ipl_mask_a: assert property (o_irq_masked == (o_cpu_ipl >= 4'h7))
		else $error("mask not level seven");
	ipl_lock_a: assert property (i_nesting_off && !i_ipl_we
		|=> $stable(o_cpu_ipl[2:0]))
		else $error("priority moved while locked");
	view_bit_a: assert property (i_wr && i_addr == 8'h44
		|=> o_psv_map == $past(i_wdata[2])) else $error("view bit wrong");
	trap_fire_a: assert property (i_dm_rd && i_dm_addr[15] && !o_psv_map
		|=> o_addr_trap) else $error("trap missing");
	trap_cause_a: assert property (o_addr_trap |-> $past(i_dm_rd)
		&& $past(i_dm_addr[15]) && !$past(o_psv_map)) else $error("stray trap");
	tbl_addr_a: assert property (o_tbl_addr[15:0] == i_tbl_ea)
		else $error("table address low part wrong");
	rd_page_a: assert property (i_wr && i_addr == 8'h62
		|=> o_rd_page == $past(i_wdata[9:0])) else $error("read page wrong");
endmodule : ccsr_regs_sva
bind ccsr_regs ccsr_regs_sva chk_u (.*);
`default_nettype wire

// file: ccsr_word_reg.sv
// one resettable register word with software and core write ports
// assumes software write and core load never needed in the same cycle
// except where core load is given priority
`timescale 1ns/10ps
`default_nettype none
module ccsr_word_reg #(
	parameter int W = 16
) (
	input  wire logic         i_mclk,  // core clock
	input  wire logic         i_rstn,  // async reset, low
	input  wire logic         i_sw_we, // software write
	input  wire logic [W-1:0] i_sw_d,  // software data
	input  wire logic         i_hw_we, // core load, wins
	input  wire logic [W-1:0] i_hw_d,  // core data
	output logic      [W-1:0] o_q      // stored value
);
	logic [W-1:0] val_reg;
	logic [W-1:0] val_next;

	// core update beats software so live counts never go stale
	assign val_next = i_hw_we ? i_hw_d : (i_sw_we ? i_sw_d : val_reg);
	assign o_q      = val_reg;

	// ***************************************************************
	// storage
	// ***************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			val_reg <= '0;
		end else begin
			val_reg <= val_next;
		end
	end
endmodule : ccsr_word_reg
`default_nettype wire

// file: cpu_core_status_control_regs_tb.sv
// self-checking bench for the core status and control bank
// assumes the bound checker and the datapath model beside it
`timescale 1ns/10ps
`default_nettype none
module cpu_core_status_control_regs_tb;
	logic i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, nest = 0, go = 0, byt = 0;
	logic lwe = 0, hwe = 0, iwe = 0, lrun = 0, dmrd = 0, fwe, fbyte, ovf, h4, h8;
	logic [7:0] addr = 8'h00;
	logic [15:0] wd = 16'h0000, a = 16'h0000, b = 16'h0000, dma = 16'h0000;
	logic [15:0] ea = 16'h1234, rdata, lcnt, ld = 16'h0000;
	logic [13:0] hd = 14'h0000, hcnt;
	logic [16:0] sum;
	logic [3:0] cpu_priority_level, ipd = 4'h0;
	logic [23:0] tbl;
	logic [9:0] rpg;
	logic [8:0] wpg;
	logic msk, program_space_view_enable, trap;
	logic [7:0] pc_high_byte = 8'h5A;
	int n_fail = 0, comparisons = 0;
	logic [7:0] ta [8] = '{8'h36, 8'h52, 8'h60, 8'h62, 8'h64, 8'h66, 8'h44, 8'h70};
	logic [15:0] te [8] = '{16'hFFFF, 16'h3FFF, 16'h005A, 16'h03FF,
		16'h01FF, 16'h00FF, 16'h000C, 16'h0000};
	always #20 i_mclk = ~i_mclk;
	ccsr_alu_model alu_u (.i_mclk(i_mclk), .i_go(go), .i_byte(byt), .i_a(a),
		.i_b(b), .o_we(fwe), .o_byte(fbyte), .o_sum(sum), .o_ovf(ovf),
		.o_hc4(h4), .o_hc8(h8));
	ccsr_regs dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(addr),
		.i_wdata(wd), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.i_nesting_off(nest), .i_flag_we(fwe), .i_op_byte(fbyte),
		.i_alu_sum(sum), .i_alu_ovf(ovf), .i_hc4(h4), .i_hc8(h8),
		.i_loop_run(lrun), .i_loop_we(lwe), .i_loop_d(ld), .i_hold_we(hwe),
		.i_hold_d(hd), .i_ipl_we(iwe), .i_ipl_d(ipd), .i_pc_high(pc_high_byte),
		.i_dm_addr(dma), .i_dm_rd(dmrd), .i_tbl_ea(ea), .o_cpu_ipl(cpu_priority_level),
		.o_irq_masked(msk), .o_psv_map(program_space_view_enable), .o_addr_trap(trap),
		.o_tbl_addr(tbl), .o_rd_page(rpg), .o_wr_page(wpg),
		.o_loop_cnt(lcnt), .o_hold_cnt(hcnt));
	// ***************************************************************
	// bus tasks and comparison
	// ***************************************************************
	task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] ad, logic [15:0] d);
		@(posedge i_mclk) begin addr <= ad; wd <= d; i_wr <= 1; end
		@(posedge i_mclk) i_wr <= 0;
	endtask : wr
	// data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] ad, logic [15:0] e);
		@(posedge i_mclk) begin addr <= ad; i_rd <= 1; end
		@(posedge i_mclk) i_rd <= 0;
		#1 chk("rdata", rdata, e);
	endtask : rd
	task automatic op(logic [15:0] x, logic [15:0] y, logic bb, logic [15:0] e);
		@(posedge i_mclk) begin a <= x; b <= y; byt <= bb; go <= 1; end
		@(posedge i_mclk) go <= 0;
		@(posedge i_mclk);
		rd(8'h42, e);
	endtask : op
	task automatic close_out;
		$display("checks %0d fails %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	// hang guard, well beyond the hundred or so cycles the tests need
	initial begin
		repeat (3000) @(posedge i_mclk);
		n_fail++;
		close_out;
	end
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1;
		for (int i = 0; i < 8; i++) rd(ta[i], i == 2 ? 16'h005A : 16'h0000);
		$display("reset test done");
		for (int i = 0; i < 8; i++) wr(ta[i], 16'hFFFF);
		for (int i = 0; i < 8; i++) rd(ta[i], te[i]);
		chk("tbl", tbl, 24'hFF1234);
		chk("pages", {rpg, wpg}, {10'h3FF, 9'h1FF});
		$display("sweep test done");
		wr(8'h44, 16'h0000);
		op(16'h7FFF, 16'h0001, 0, 16'h010C);
		op(16'hFFFF, 16'h0001, 0, 16'h0103);
		op(16'h000F, 16'h0001, 1, 16'h0100);
		op(16'h0000, 16'h0000, 1, 16'h0002);
		lrun <= 1;
		rd(8'h42, 16'h0012);
		lrun <= 0;
		$display("flag test done");
		wr(8'h42, 16'h00E0);
		wr(8'h44, 16'h0008);
		#1 chk("ipl", {msk, cpu_priority_level}, 5'h1F);
		wr(8'h42, 16'h00C0);
		wr(8'h44, 16'h0000);
		#1 chk("ipl", {msk, cpu_priority_level}, 5'h06);
		nest <= 1;
		wr(8'h42, 16'h0020);
		rd(8'h42, 16'h00C0);
		@(posedge i_mclk) begin iwe <= 1; ipd <= 4'h3; end
		@(posedge i_mclk) begin iwe <= 0; nest <= 0; end
		#1 chk("ipl", cpu_priority_level, 4'h3);
		$display("priority test done");
		@(posedge i_mclk) begin dmrd <= 1; dma <= 16'h8000; end
		@(posedge i_mclk) dma <= 16'h7FFF;
		#1 chk("trap", trap, 1);
		@(posedge i_mclk) dmrd <= 0;
		#1 chk("trap", trap, 0);
		wr(8'h44, 16'h0004);
		@(posedge i_mclk) begin dmrd <= 1; dma <= 16'h8000; end
		@(posedge i_mclk) dmrd <= 0;
		#1 chk("view", {program_space_view_enable, trap}, 2'b10);
		$display("view test done");
		@(posedge i_mclk) begin
			addr <= 8'h36; wd <= 16'h1111; i_wr <= 1; lwe <= 1; ld <= 16'h2222;
			hwe <= 1; hd <= 14'h1234;
		end
		@(posedge i_mclk) begin i_wr <= 0; lwe <= 0; hwe <= 0; end
		#1 chk("counts", {lcnt, hcnt[7:0]}, 24'h222234);
		rd(8'h52, 16'h1234);
		pc_high_byte <= 8'hA5;
		rd(8'h60, 16'h00A5);
		$display("core load test done");
		close_out;
	end
endmodule : cpu_core_status_control_regs_tb
`default_nettype wire
